//--- logic/rtc_alarm_cfg.svh
// register offsets, field positions and reset values of the alarm match block
`ifndef RTC_ALARM_CFG_SVH
`define RTC_ALARM_CFG_SVH
`define ALM0_WDAY_ADDR 8'h0f
`define ALM0_DATE_ADDR 8'h10
`define ALM0_MONTH_ADDR 8'h11
`define ALM1_SUBSEC_ADDR 8'h12
`define ALM1_SEC_ADDR 8'h13
`define ALM1_MIN_ADDR 8'h14
`define REG_RESET 8'h00
`define OUTSEL_BIT 7
`define COND_MSB 6
`define COND_LSB 4
`define FLAG_BIT 3
`define WDAY_MASK 8'h07
`define DATE_MASK 8'h3f
`define MONTH_MASK 8'h1f
`define SEC_MASK 8'h7f
`define FMT_BIT 6
`define MIDNIGHT_HOUR 8'h12
`define ZERO_BCD 8'h00
`define PM_BIT 5
`define HOUR12_MASK 8'h1f
`define HOUR24_MASK 8'h3f
`endif

//--- logic/rtc_alarm_pkg.sv
// types shared by the alarm match block
package rtc_alarm_pkg;
    typedef enum logic [2:0] {
        COND_SECONDS = 3'h0,
        COND_MINUTES = 3'h1,
        COND_HOURS = 3'h2,
        COND_WEEKDAY = 3'h3,
        COND_DATE = 3'h4,
        COND_RSVD5 = 3'h5,
        COND_RSVD6 = 3'h6,
        COND_ALL = 3'h7
    } match_cond_e;
    typedef logic [7:0] byte_t;
endpackage : rtc_alarm_pkg

//--- logic/rtc_tick_edge.sv
// one-cycle pulse on each rising edge of a same-clock update strobe
`timescale 1ns/1ns
`default_nettype none
module rtc_tick_edge (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // strobe in, pulse out
    input wire logic level_i,
    output logic pulse_o
);
    logic prev_reg;
    logic prev_next;

    // next value
    always_comb begin
        prev_next = level_i;
    end

    // register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
        end
    end

    assign pulse_o = level_i & ~prev_reg;
endmodule : rtc_tick_edge
`default_nettype wire

//--- logic/rtc_hour_cmp.sv
// hour comparison that honours 12-hour and 24-hour formats
`timescale 1ns/1ns
`default_nettype none
`include "rtc_alarm_cfg.svh"
module rtc_hour_cmp
    import rtc_alarm_pkg::*;
(
    // hour values in timekeeping layout
    input wire logic [7:0] time_hour_i,
    input wire logic [7:0] alarm_hour_i,
    // result
    output logic match_o
);
    // in 12-hour mode bit 5 is am/pm and is compared; in 24-hour it is a tens bit
    always_comb begin
        if (time_hour_i[`FMT_BIT]) begin
            match_o = ((time_hour_i & `HOUR12_MASK) == (alarm_hour_i & `HOUR12_MASK)) &&
                      (time_hour_i[`PM_BIT] == alarm_hour_i[`PM_BIT]); // RULE_03
        end else begin
            match_o = (time_hour_i & `HOUR24_MASK) == (alarm_hour_i & `HOUR24_MASK); // RULE_03
        end
    end
endmodule : rtc_hour_cmp
`default_nettype wire

//--- logic/rtc_alarm_match.sv
// alarm match registers and comparators of the real-time clock
//
// Overview of operation
// (RULE_01) bit 7 picks irq pin or watchdog pin
// (RULE_02) codes 000,001,100 match seconds, minutes, date
// (RULE_03) code 010 matches hours, honouring 12/24 format
// (RULE_04) code 011 matches weekday at midnight
// (RULE_05) host never programs codes 101 or 110
// (RULE_06) code 111 needs every field matching
// (RULE_07) flag bit 3 set on alarm, host clears
// (RULE_08) weekday held in low three bits, 1-7
// (RULE_09) date tens bits 5-4, units 3-0
// (RULE_10) month tens bit 4, units 3-0
// (RULE_11) month compare exists only for first alarm
// (RULE_12) sub-second compare only on second alarm
// (RULE_13) sub-second register: tenths high, hundredths low
// (RULE_14) second alarm seconds: tens 6-4, units 3-0
// (RULE_15) second alarm minutes: tens 6-4, units 3-0
// (RULE_16) alarm hour format bit mirrors timekeeping hour
// (RULE_17) compare on each update, fire once per match
`timescale 1ns/1ns
`default_nettype none
`include "rtc_alarm_cfg.svh"
module rtc_alarm_match
    import rtc_alarm_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register port from the serial interface
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    output logic [7:0] reg_rdata_o,
    // running timekeeping counters, bcd, same clock
    input wire logic time_update_i,
    input wire logic [7:0] time_subsec_i,
    input wire logic [7:0] time_sec_i,
    input wire logic [7:0] time_min_i,
    input wire logic [7:0] time_hour_i,
    input wire logic [7:0] time_wday_i,
    input wire logic [7:0] time_date_i,
    input wire logic [7:0] time_month_i,
    // first alarm seconds, minutes and hour match values from their own registers, timekeeping layout
    input wire logic [7:0] alarm0_sec_i,
    input wire logic [7:0] alarm0_min_i,
    input wire logic [7:0] alarm0_hour_i,
    // alarm outputs
    output logic alarm0_irq_o,
    output logic alarm0_watchdog_o,
    output logic alarm1_match_o
);
    // host-visible match registers of both alarms
    byte_t wday_reg;
    byte_t wday_next;
    byte_t date_reg;
    byte_t date_next;
    byte_t month_reg;
    byte_t month_next;
    byte_t subsec_reg;
    byte_t subsec_next;
    byte_t sec1_reg;
    byte_t sec1_next;
    byte_t min1_reg;
    byte_t min1_next;
    // registered read data and pin levels
    byte_t rdata_reg;
    byte_t rdata_next;
    logic irq_reg;
    logic irq_next;
    logic wdo_reg;
    logic wdo_next;
    // second alarm result, held between updates
    logic a1_reg;
    logic a1_next;
    // one compare cycle per rising update strobe
    logic update_pulse;
    // first alarm field results
    logic hour_hit;
    logic sec_hit;
    logic min_hit;
    logic wday_hit;
    logic date_hit;
    logic month_hit;
    logic midnight_hour;
    logic midnight;
    logic a0_hit;
    logic flag_set;
    // second alarm field results
    logic a1_subsec_hit;
    logic a1_sec_hit;
    logic a1_min_hit;
    logic a1_hit;
    // host write strobes, one per match register
    logic wr_wday;
    logic wr_date;
    logic wr_month;
    logic wr_subsec;
    logic wr_sec1;
    logic wr_min1;
    // alarm hour with the live format bit patched in, and the decoded condition
    byte_t hour_cmp_value;
    match_cond_e cond;

    // update strobe becomes a single compare cycle
    rtc_tick_edge u_tick (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .level_i(time_update_i),
        .pulse_o(update_pulse)
    );

    // alarm hour format bit follows the live clock so the host need not set it
    always_comb begin
        hour_cmp_value = alarm0_hour_i;
        hour_cmp_value[`FMT_BIT] = time_hour_i[`FMT_BIT]; // RULE_16
    end

    rtc_hour_cmp u_hour (
        .time_hour_i(time_hour_i),
        .alarm_hour_i(hour_cmp_value),
        .match_o(hour_hit)
    );

    // first alarm field comparators; reserved bits of the live counters are ignored
    always_comb begin
        cond = match_cond_e'(wday_reg[`COND_MSB:`COND_LSB]);
        sec_hit = (time_sec_i & `SEC_MASK) == (alarm0_sec_i & `SEC_MASK);
        min_hit = (time_min_i & `SEC_MASK) == (alarm0_min_i & `SEC_MASK);
        wday_hit = (time_wday_i & `WDAY_MASK) == (wday_reg & `WDAY_MASK); // RULE_08
        date_hit = (time_date_i & `DATE_MASK) == date_reg; // RULE_09
        month_hit = (time_month_i & `MONTH_MASK) == month_reg; // RULE_10 RULE_11
    end

    // midnight is 12 am in 12-hour mode and hour zero in 24-hour mode
    always_comb begin
        if (time_hour_i[`FMT_BIT]) begin
            midnight_hour = (time_hour_i & `HOUR24_MASK) == `MIDNIGHT_HOUR; // RULE_04
        end else begin
            midnight_hour = (time_hour_i & `HOUR24_MASK) == `ZERO_BCD; // RULE_04
        end
        midnight = midnight_hour && ((time_sec_i & `SEC_MASK) == `ZERO_BCD) &&
                   ((time_min_i & `SEC_MASK) == `ZERO_BCD); // RULE_04
    end

    // condition code picks which comparison raises the first alarm
    always_comb begin
        case (cond)
            COND_SECONDS: a0_hit = sec_hit; // RULE_02
            COND_MINUTES: a0_hit = min_hit; // RULE_02
            COND_HOURS: a0_hit = hour_hit; // RULE_03
            COND_WEEKDAY: a0_hit = wday_hit && midnight; // RULE_04
            COND_DATE: a0_hit = date_hit; // RULE_02
            COND_ALL: a0_hit = sec_hit && min_hit && hour_hit && wday_hit && date_hit && month_hit; // RULE_06
            default: a0_hit = 1'b0; // codes 101 and 110 never fire
        endcase
        // a match may set the flag only on the rising update strobe, so a held strobe fires once
        flag_set = update_pulse && a0_hit; // RULE_07 RULE_17
    end

    // second alarm: sub-second, seconds and minutes; it has no month field
    always_comb begin
        // tenths and hundredths exist only here, the first alarm has no sub-second field
        a1_subsec_hit = time_subsec_i == subsec_reg; // RULE_12 RULE_13
        a1_sec_hit = (time_sec_i & `SEC_MASK) == sec1_reg; // RULE_14
        a1_min_hit = (time_min_i & `SEC_MASK) == min1_reg; // RULE_15
        a1_hit = a1_subsec_hit && a1_sec_hit && a1_min_hit; // RULE_11
    end

    // host write decode; writes to unmapped offsets match no strobe and are dropped
    always_comb begin
        // write data lands at the same edge; reserved bits are masked in the next-value logic
        wr_wday = reg_we_i && (reg_addr_i == `ALM0_WDAY_ADDR);
        wr_date = reg_we_i && (reg_addr_i == `ALM0_DATE_ADDR);
        wr_month = reg_we_i && (reg_addr_i == `ALM0_MONTH_ADDR);
        wr_subsec = reg_we_i && (reg_addr_i == `ALM1_SUBSEC_ADDR);
        wr_sec1 = reg_we_i && (reg_addr_i == `ALM1_SEC_ADDR);
        wr_min1 = reg_we_i && (reg_addr_i == `ALM1_MIN_ADDR);
    end

    // first alarm control and match registers: next values
    always_comb begin
        wday_next = wday_reg;
        date_next = date_reg;
        month_next = month_reg;
        // the whole control byte is writable, flag included
        if (wr_wday) begin
            wday_next = reg_wdata_i;
        end
        if (wr_date) begin
            date_next = reg_wdata_i & `DATE_MASK; // RULE_09
        end
        if (wr_month) begin
            month_next = reg_wdata_i & `MONTH_MASK; // RULE_10
        end
        // a match wins over a host clear in the same cycle, so no alarm is lost
        if (flag_set) begin
            wday_next[`FLAG_BIT] = 1'b1; // RULE_07
        end
    end

    // first alarm registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wday_reg <= `REG_RESET;
            date_reg <= `REG_RESET;
            month_reg <= `REG_RESET;
        end else begin
            wday_reg <= wday_next;
            date_reg <= date_next;
            month_reg <= month_next;
        end
    end

    // second alarm match registers: next values
    always_comb begin
        subsec_next = subsec_reg;
        sec1_next = sec1_reg;
        min1_next = min1_reg;
        // bit 7 of seconds and minutes always reads zero
        if (wr_subsec) begin
            subsec_next = reg_wdata_i; // RULE_13
        end
        if (wr_sec1) begin
            sec1_next = reg_wdata_i & `SEC_MASK; // RULE_14
        end
        if (wr_min1) begin
            min1_next = reg_wdata_i & `SEC_MASK; // RULE_15
        end
    end

    // second alarm match registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            subsec_reg <= `REG_RESET;
            sec1_reg <= `REG_RESET;
            min1_reg <= `REG_RESET;
        end else begin
            subsec_reg <= subsec_next;
            sec1_reg <= sec1_next;
            min1_reg <= min1_next;
        end
    end

    // second alarm result is sampled once per update and held until the next
    always_comb begin
        a1_next = a1_reg;
        if (update_pulse) begin
            a1_next = a1_hit; // RULE_17
        end
    end

    // second alarm result register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            a1_reg <= 1'b0;
        end else begin
            a1_reg <= a1_next;
        end
    end

    // flag drives the selected pin; the other stays quiet
    always_comb begin
        irq_next = wday_reg[`FLAG_BIT] && !wday_reg[`OUTSEL_BIT]; // RULE_01
        wdo_next = wday_reg[`FLAG_BIT] && wday_reg[`OUTSEL_BIT]; // RULE_01
    end

    // pin registers; the flag is latched first, so a pin lags it by one cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_reg <= 1'b0;
            wdo_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
            wdo_reg <= wdo_next;
        end
    end

    // read mux; registered, so data follows the address by one cycle
    always_comb begin
        case (reg_addr_i)
            `ALM0_WDAY_ADDR: rdata_next = wday_reg;
            `ALM0_DATE_ADDR: rdata_next = date_reg;
            `ALM0_MONTH_ADDR: rdata_next = month_reg;
            `ALM1_SUBSEC_ADDR: rdata_next = subsec_reg;
            `ALM1_SEC_ADDR: rdata_next = sec1_reg;
            `ALM1_MIN_ADDR: rdata_next = min1_reg;
            // unmapped offsets read as zero
            default: rdata_next = `REG_RESET;
        endcase
    end

    // read data register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_reg <= `REG_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // every output comes straight from a flip-flop
    assign reg_rdata_o = rdata_reg;
    assign alarm0_irq_o = irq_reg;
    assign alarm0_watchdog_o = wdo_reg;
    assign alarm1_match_o = a1_reg;
endmodule : rtc_alarm_match
`default_nettype wire

//--- bench/rtc_alarm_match_monitor.sv
// port checks for the alarm match block
`timescale 1ns/1ns
`default_nettype none
module rtc_alarm_match_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic [7:0] reg_rdata_o,
    // alarm side
    input wire logic time_update_i,
    input wire logic alarm0_irq_o,
    input wire logic alarm0_watchdog_o,
    input wire logic alarm1_match_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // read data follows the address of the previous edge
    pin_exclusive_a: assert property (!(alarm0_irq_o && alarm0_watchdog_o)) else $error("both pins");
    date_top_zero_a: assert property ($past(reg_addr_i) == 8'h10 |-> reg_rdata_o[7:6] == 2'h0) else $error("date");
    month_top_zero_a: assert property ($past(reg_addr_i) == 8'h11 |-> reg_rdata_o[7:5] == 3'h0) else $error("mon");
    sec_top_zero_a: assert property ($past(reg_addr_i) == 8'h13 |-> !reg_rdata_o[7]) else $error("sec");
    min_top_zero_a: assert property ($past(reg_addr_i) == 8'h14 |-> !reg_rdata_o[7]) else $error("min");
    // a pin may only rise two edges after the update strobe rose, never on a held strobe
    pin_after_update_a: assert property (
        $rose(alarm0_irq_o || alarm0_watchdog_o) |-> $past(time_update_i, 2) && !$past(time_update_i, 3)) else $error("pin");
    sec_readback_a: assert property (
        reg_we_i && reg_addr_i == 8'h13 ##1 reg_addr_i == 8'h13 |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h7f))
        else $error("sec wr");
    subsec_readback_a: assert property (
        reg_we_i && reg_addr_i == 8'h12 ##1 reg_addr_i == 8'h12 |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("sub wr");
    cover property ($rose(alarm0_irq_o));
    cover property ($rose(alarm0_watchdog_o));
    cover property ($rose(alarm1_match_o));
endmodule : rtc_alarm_match_monitor
bind rtc_alarm_match rtc_alarm_match_monitor u_rtc_alarm_match_monitor (.clk_i, .srst_i, .reg_addr_i, .reg_wdata_i,
    .reg_we_i, .reg_rdata_o, .time_update_i, .alarm0_irq_o, .alarm0_watchdog_o, .alarm1_match_o);
`default_nettype wire

//--- bench/rtc_host_model.sv
// host side of the register port: single byte writes and reads
`timescale 1ns/1ns
`default_nettype none
module rtc_host_model (
    // clock
    input wire logic clk_i,
    // register port toward the block
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_we_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_we_o = 1'b0;
    end
    // one strobe per byte; data inverted afterwards so a late sample cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_we_o = 1'b1;
        @(negedge clk_i);
        reg_we_o = 1'b0;
        reg_wdata_o = ~d;
    endtask : wr
    // read data is registered, so the address is held across one edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        @(negedge clk_i);
        d = reg_rdata_i;
    endtask : rd
endmodule : rtc_host_model
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the alarm match block
`timescale 1ns/1ns
`default_nettype none
module testbench import rtc_alarm_pkg::*;;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic time_update_i = 1'b0;
    logic we, irq, watchdog_output_pin, m1;
    byte_t ra, rw, rr, rd_v;
    byte_t tm [7];
    byte_t a0 [3];
    byte_t regs [7] = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
    byte_t msk [7] = '{8'hf7, 8'h3f, 8'h1f, 8'hff, 8'h7f, 8'h7f, 8'h00};
    int fld [8] = '{1, 2, 3, 3, 5, 1, 1, 6};
    int miscompares = 0;
    int comparisons = 0;
    rtc_alarm_match u_rtc_alarm_match (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(ra), .reg_wdata_i(rw),
        .reg_we_i(we), .reg_rdata_o(rr), .time_update_i(time_update_i), .time_subsec_i(tm[0]),
        .time_sec_i(tm[1]), .time_min_i(tm[2]), .time_hour_i(tm[3]), .time_wday_i(tm[4]),
        .time_date_i(tm[5]), .time_month_i(tm[6]), .alarm0_sec_i(a0[0]), .alarm0_min_i(a0[1]),
        .alarm0_hour_i(a0[2]), .alarm0_irq_o(irq), .alarm0_watchdog_o(watchdog_output_pin), .alarm1_match_o(m1));
    rtc_host_model u_rtc_host_model (.clk_i(clk_i), .reg_addr_o(ra), .reg_wdata_o(rw), .reg_we_o(we),
        .reg_rdata_i(rr));
    initial forever #5 clk_i = ~clk_i;
    task automatic chk_byte(input byte_t got, input byte_t exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_pin(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask : chk_pin
    task automatic conclude;
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    // one update at midnight of hour byte h, optionally spoiling the field the code looks at;
    // the spoil flips bit 4, which the masks of all spoiled fields keep, so the field truly differs
    task automatic trial(input logic [2:0] c, input logic spoil, input byte_t h);
        logic fire;
        int f;
        f = fld[c];
        fire = !(c inside {3'h5, 3'h6}) && !spoil;
        u_rtc_host_model.wr(8'h0f, {c[0], c, 1'b0, 3'h3});
        tm = '{8'h45, 8'h00, 8'h00, h, 8'h03, 8'h15, 8'h12};
        a0[2] = h;
        if (spoil) tm[f] = tm[f] ^ 8'h10;
        time_update_i = 1'b1;
        @(negedge clk_i);
        time_update_i = 1'b0;
        @(negedge clk_i);
        chk_pin(irq, fire & !c[0]);
        chk_pin(watchdog_output_pin, fire & c[0]);
        chk_pin(m1, !(spoil && f inside {1, 2}));
        u_rtc_host_model.rd(8'h0f, rd_v);
        chk_byte(rd_v, {c[0], c, fire, 3'h3});
        u_rtc_host_model.wr(8'h0f, {c[0], c, 1'b0, 3'h3});
        u_rtc_host_model.rd(8'h0f, rd_v);
        chk_byte(rd_v, {c[0], c, 1'b0, 3'h3});
    endtask : trial
    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        conclude();
    end
    initial begin
        tm = '{default: 8'h00};
        a0 = '{8'h00, 8'h00, 8'h52};
        repeat (10) @(negedge clk_i);
        srst_i = 1'b0;
        // reset values, then masked readback, the last address being unmapped
        for (int i = 0; i < 7; i++) begin
            u_rtc_host_model.rd(regs[i], rd_v);
            chk_byte(rd_v, 8'h00);
            u_rtc_host_model.wr(regs[i], 8'hf7);
            u_rtc_host_model.rd(regs[i], rd_v);
            chk_byte(rd_v, 8'hf7 & msk[i]);
        end
        u_rtc_host_model.wr(8'h10, 8'h15);
        u_rtc_host_model.wr(8'h11, 8'h12);
        u_rtc_host_model.wr(8'h12, 8'h45);
        u_rtc_host_model.wr(8'h13, 8'h00);
        u_rtc_host_model.wr(8'h14, 8'h00);
        // 12-hour pass at 12 AM, then 24-hour pass at hour zero
        for (int h = 0; h < 2; h++) begin
            for (int c = 0; c < 8; c++) begin
                trial(3'(c), 1'b0, (h == 0) ? 8'h52 : 8'h00);
                trial(3'(c), 1'b1, (h == 0) ? 8'h52 : 8'h00);
            end
        end
        conclude();
    end
endmodule : testbench
`default_nettype wire
